// *** hw/led_blink_pwm_output_stage.sv ***
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module led_blink_pwm_output_stage
    import led_pwm_pkg::*;
#(
    parameter int SLOT_DIV = 4
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register port.
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Open-drain outputs, output enable high while sinking.
    output logic [PORT_N-1:0] port_out_o,
    output logic [PORT_N-1:0] port_oe_o,
    output logic ninth_output_out_o,
    output logic ninth_output_oe_o
);
    // Refuse divider settings that the 16-bit slot divider cannot count.
    generate
        if (SLOT_DIV < 1 || SLOT_DIV > 65535) begin : g_bad_div
            $error("SLOT_DIV out of range");
        end
    endgenerate

    // Row index width of the per-port intensity table.
    localparam int IDX_W = $clog2(PORT_N);

    // Software-visible settings.
    logic [7:0] ctrl;
    logic [3:0] master;
    logic [7:0] phase0;
    logic [7:0] phase1;
    logic [7:0] ninth_reg;
    logic [3:0] intens [PORT_N];
    // Slot timing.
    logic [15:0] div_cnt;
    logic slot_en;
    logic [3:0] slot;
    logic osc_run;
    // Per-output decisions and pin drive.
    logic [PORT_N-1:0] next_low;
    logic next_ninth_low;
    logic [PORT_N-1:0] port_sink;
    logic ninth_sink;
    od_pin_t port_drv [PORT_N];
    od_pin_t ninth_drv;

    // Decides whether an output sinks in the current slot. The top setting
    // bypasses the compare entirely, so it gives a level with no PWM edges,
    // and the inversion then turns that static sink into a static release.
    function automatic logic sink_now(input logic [3:0] n, input logic inv, input logic [3:0] s);
        logic base;
        base = 1'b0;
        if (n == INT_STATIC) begin
            base = 1'b1;
        end else begin
            base = (s <= n);
        end
        return base ^ inv;
    endfunction

    // Chooses the active polarity bit from the blink state.
    function automatic logic pick_phase(input logic p0, input logic p1, input logic en, input logic ph);
        return (en && ph) ? p1 : p0;
    endfunction

    // True when an address falls in the per-port intensity table.
    // Both the write decode and the read mux use it, so they cannot drift apart.
    function automatic logic int_hit(input logic [3:0] a);
        return a >= ADDR_INT_BASE;
    endfunction

    // Table row for an intensity address; only meaningful when int_hit is true.
    // The subtraction is cut to the row width on purpose.
    function automatic logic [IDX_W-1:0] int_index(input logic [3:0] a);
        return IDX_W'(a - ADDR_INT_BASE);
    endfunction

    // Master intensity only gates the oscillator here; there is no coarse
    // duty scaling, so any nonzero master value runs the slots at full rate.
    // A zero value stops the divider and the slot counter together.
    assign osc_run = (master != MASTER_OFF);

    // Register writes. Unmapped addresses fall through the default branch,
    // so a stray write cannot disturb a live setting. A new value takes effect
    // on the pins two edges after the strobe, one for the register and one for
    // the drive flip-flops.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl <= RST_BYTE;
            master <= RST_NIB;
            phase0 <= RST_BYTE;
            phase1 <= RST_BYTE;
            ninth_reg <= RST_BYTE;
        end else if (wr_i) begin
            case (addr_i)
                ADDR_CTRL: ctrl <= wdata_i;
                ADDR_MASTER: master <= wdata_i[3:0];
                ADDR_PHASE0: phase0 <= wdata_i;
                ADDR_PHASE1: phase1 <= wdata_i;
                ADDR_NINTH: ninth_reg <= wdata_i;
                default: ;
            endcase
        end
    end

    // Per-output intensity registers, one per port. Only the low nibble of the
    // write data is kept, since the compare works on four bits.
    genvar gi;
    generate
        for (gi = 0; gi < PORT_N; gi++) begin : g_int
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    intens[gi] <= RST_NIB;
                end else if (wr_i && int_hit(addr_i) && int_index(addr_i) == IDX_W'(gi)) begin
                    intens[gi] <= wdata_i[3:0];
                end
            end
        end
    endgenerate

    // Read data one cycle after the strobe; unmapped addresses read zero.
    // The data bus returns to zero in every other cycle, so a late sample by
    // software shows an obvious zero rather than a stale register.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= RST_BYTE;
        end else if (rd_i) begin
            // The intensity table holds four bits a row; the upper nibble reads zero.
            if (int_hit(addr_i)) begin
                rdata_o <= {4'h0, intens[int_index(addr_i)]};
            end else begin
                case (addr_i)
                    ADDR_CTRL: rdata_o <= ctrl;
                    ADDR_MASTER: rdata_o <= {4'h0, master};
                    ADDR_PHASE0: rdata_o <= phase0;
                    ADDR_PHASE1: rdata_o <= phase1;
                    ADDR_NINTH: rdata_o <= ninth_reg;
                    ADDR_STATUS: rdata_o <= {3'h0, osc_run, slot};
                    default: rdata_o <= RST_BYTE;
                endcase
            end
        end else begin
            rdata_o <= RST_BYTE;
        end
    end

    // Slot divider; it clears and halts with the oscillator so the slot counter freezes.
    // Clearing the count while stopped means that a restart always begins
    // with a slot of full length, at the price of the phase that the
    // interrupted slot had reached.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !osc_run) begin
            div_cnt <= 16'h0000;
            slot_en <= 1'b0;
        end else if (div_cnt == 16'(SLOT_DIV - 1)) begin
            div_cnt <= 16'h0000;
            slot_en <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            slot_en <= 1'b0;
        end
    end

    // Sixteen-slot period counter. The slot only moves while the oscillator
    // runs: a divider pulse still in flight when master intensity drops to
    // zero is dropped, so the slot count stops at the edge the setting lands.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            slot <= RST_NIB;
        end else if (slot_en && osc_run) begin
            slot <= (slot == SLOT_LAST) ? RST_NIB : slot + 4'h1;
        end
    end

    // Waveform decisions. With the oscillator stopped the slot count sits still,
    // so every output holds a static level. Setting changes still reach the
    // pins while stopped; they simply no longer pulse.
    always_comb begin
        for (int i = 0; i < PORT_N; i++) begin
            // One shared phase register pair drives the whole group.
            next_low[i] = sink_now(intens[i], pick_phase(phase0[i], phase1[i],
                ctrl[CTRL_BLINK_EN], ctrl[CTRL_BLINK_PH]), slot);
        end
        next_ninth_low = sink_now(ninth_reg[3:0], pick_phase(ninth_reg[NINTH_PH0],
            ninth_reg[NINTH_PH1], ctrl[CTRL_BLINK_EN], ctrl[CTRL_BLINK_PH]), slot);
    end

    // Sink decisions land in flip-flops so the pins never glitch while the
    // slot count and the settings ripple through the compare logic.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            port_sink <= '0;
            ninth_sink <= 1'b0;
        end else begin
            port_sink <= next_low;
            ninth_sink <= next_ninth_low;
        end
    end

    // Pack each pin's drive. An open-drain pin can only pull low, so its level
    // is fixed and the enable alone decides whether it sinks or floats.
    generate
        for (gi = 0; gi < PORT_N; gi++) begin : g_pin
            assign port_drv[gi] = '{out: 1'b0, oe: port_sink[gi]};
            assign port_out_o[gi] = port_drv[gi].out;
            assign port_oe_o[gi] = port_drv[gi].oe;
        end
    endgenerate

    // The ninth output has its own register and its own compare, so it is
    // packed on its own and may switch apart from the group.
    assign ninth_drv = '{out: 1'b0, oe: ninth_sink};
    assign ninth_output_out_o = ninth_drv.out;
    assign ninth_output_oe_o = ninth_drv.oe;
endmodule
`default_nettype wire

// *** hw/led_pwm_pkg.sv ***
// Function
// - Phase bit zero: low for n+1 slots.
// - Phase bit one: waveform inverted, low 15-n.
// - Setting 0xF, bit zero: static low.
// - Setting 0xF, bit one: static high-impedance.
// - Setting 0x7 gives half duty either phase.
// - Blink phase selects phase-zero or phase-one bit.
// - Eight-port group shares one phase register.
// - Ninth output uses its own register.
// - Master intensity zero stops oscillator, outputs static.
// - Blink disabled: only phase-zero bit applies.
package led_pwm_pkg;
    localparam int INT_W = 4;
    localparam logic [3:0] INT_STATIC = 4'hf;
    localparam logic [3:0] MASTER_OFF = 4'h0;
    localparam logic [3:0] SLOT_LAST = 4'hf;
    localparam int PORT_N = 8;

    // Register offsets for the plain register port.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MASTER = 4'h1;
    localparam logic [3:0] ADDR_PHASE0 = 4'h2;
    localparam logic [3:0] ADDR_PHASE1 = 4'h3;
    localparam logic [3:0] ADDR_NINTH = 4'h4;
    localparam logic [3:0] ADDR_INT_BASE = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h5;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;

    // Control register bit positions.
    localparam int CTRL_BLINK_EN = 0;
    localparam int CTRL_BLINK_PH = 1;

    // Ninth output register layout.
    localparam int NINTH_PH0 = 4;
    localparam int NINTH_PH1 = 5;

    // Drive of one open-drain output.
    typedef struct packed {
        logic out;
        logic oe;
    } od_pin_t;
endpackage

// *** verification/led_loads.sv ***
`timescale 1ns/10ps
`default_nettype none
// Loads with pull-ups: a released pin reads high, never the last driven value.
module led_loads (
    input wire logic [8:0] oe_i,
    input wire logic [8:0] out_i,
    output logic [8:0] pin_o
);
    assign pin_o = (oe_i & out_i) | ~oe_i;
endmodule
`default_nettype wire

// *** verification/led_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module led_props #(parameter int SLOT_DIV = 4) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wr_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] port_out_o,
    input wire logic [7:0] port_oe_o,
    input wire logic ninth_output_out_o,
    input wire logic ninth_output_oe_o
);
    // Shadow registers; q is nonzero for two cycles after a write settles in.
    logic [7:0] r [16];
    logic [1:0] q;
    wire b = r[0][0] & r[0][1];
    wire a = b ? r[3][0] : r[2][0];
    wire n = b ? r[4][5] : r[4][4];
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            r <= '{default: 8'h00};
            q <= 2'h3;
        end else begin
            q <= {q[0], wr_i};
            if (wr_i)
                r[addr_i] <= wdata_i;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    od_low_a: assert property (port_out_o == 8'h00 && !ninth_output_out_o) else $error("pin level");
    st_low_a: assert property (q == 0 && r[8][3:0] == 4'hf && !a |-> port_oe_o[0])
        else $error("st low");
    st_hiz_a: assert property (q == 0 && r[8][3:0] == 4'hf && a |-> !port_oe_o[0])
        else $error("st hiz");
    nine_low_a: assert property (q == 0 && r[4][3:0] == 4'hf && !n |-> ninth_output_oe_o)
        else $error("9 low");
    nine_hiz_a: assert property (q == 0 && r[4][3:0] == 4'hf && n |-> !ninth_output_oe_o)
        else $error("9 hiz");
    port_group_a: assert property (q == 0 && r[8] == r[15] && r[2][0] == r[2][7] && r[3][0] == r[3][7]
        |-> port_oe_o[0] == port_oe_o[7]) else $error("group");
    osc_frozen_a: assert property (q == 0 && r[1][3:0] == 4'h0
        |-> $stable(port_oe_o) && $stable(ninth_output_oe_o)) else $error("frozen");
    slot_step_a: assert property (SLOT_DIV > 1 && q == 0 && $changed(port_oe_o) |=> $stable(port_oe_o))
        else $error("slot step");
endmodule
bind led_blink_pwm_output_stage led_props #(.SLOT_DIV(SLOT_DIV)) props_u (.clk_i, .rst_b_i, .wr_i,
    .addr_i, .wdata_i, .port_out_o, .port_oe_o, .ninth_output_out_o, .ninth_output_oe_o);
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import led_pwm_pkg::*;
    logic clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, no, ne;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, po, pe;
    logic [8:0] pin;
    int mismatches = 0, num_checks = 0, cyc = 0, cnt [9];
    led_blink_pwm_output_stage #(.SLOT_DIV(4)) dut_u (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .port_out_o(po), .port_oe_o(pe), .ninth_output_out_o(no), .ninth_output_oe_o(ne));
    led_loads load_u (.oe_i({ne, pe}), .out_i({no, po}), .pin_o(pin));
    initial forever #12.5 clk_i = ~clk_i;
    // A hang is cut short well above the few thousand cycles the run needs.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", e, rdata_o);
    endtask
    // One period is 16 slots of 4 cycles, so any 64-cycle window sees the exact duty.
    task automatic meas();
        int unk;
        unk = 0;
        repeat (3) @(posedge clk_i);
        cnt = '{default: 0};
        repeat (64) begin
            @(posedge clk_i);
            #1;
            for (int i = 0; i < 9; i++) begin
                unk += int'($isunknown(pin[i]));
                cnt[i] += int'(pin[i] === 1'b0);
            end
        end
        chk("pin known", 8'h00, {7'h00, unk != 0});
    endtask
    task automatic t_duty();
        wr(ADDR_MASTER, 8'h01);
        for (int v = 0; v < 2; v++) begin
            wr(ADDR_PHASE0, v ? 8'hff : 8'h00);
            for (int n = 0; n < 16; n++) begin
                for (int p = 0; p < 8; p++)
                    wr(ADDR_INT_BASE + 4'(p), 8'(n));
                wr(ADDR_NINTH, {3'h0, 1'(v), 4'(n)});
                meas();
                for (int i = 0; i < 9; i++)
                    chk("duty", 8'(n == 15 ? 64 * (1 - v) : 4 * (v ? 15 - n : n + 1)),
                        8'(cnt[i]));
            end
        end
        $display("duty test done");
    endtask
    task automatic t_blink();
        for (int p = 0; p < 8; p++)
            wr(ADDR_INT_BASE + 4'(p), 8'h03);
        wr(ADDR_NINTH, 8'h23);
        wr(ADDR_PHASE0, 8'h00);
        wr(ADDR_PHASE1, 8'hff);
        for (int c = 1; c < 4; c++) begin
            wr(ADDR_CTRL, 8'(c));
            meas();
            for (int i = 0; i < 9; i++)
                chk("blink", c == 3 ? 8'h30 : 8'h10, 8'(cnt[i]));
        end
        $display("blink test done");
    endtask
    task automatic t_stop();
        rd(ADDR_MASTER, 8'h01);
        rd(ADDR_INT_BASE, 8'h03);
        rd(ADDR_NINTH, 8'h23);
        rd(4'h6, 8'h00);
        wr(ADDR_MASTER, 8'(MASTER_OFF));
        meas();
        for (int i = 0; i < 9; i++)
            chk("frozen", 8'h00, 8'(cnt[i] % 64));
        $display("stop test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_duty();
        t_blink();
        t_stop();
        wrap_up();
    end
endmodule
`default_nettype wire
